//--- core/dtp_regs.svh
/*
 timing constants and field widths for the timer pacer block.
 assumes inclusion by bare name from core files.
*/
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH
`define DTP_CNT_W        16
`define DTP_MIN_DIV      16'h0002
`define DTP_RST_DIV      16'hffff
`define DTP_DATA_W       32
`define DTP_TB_HZ        4000000
`define DTP_CLK_HZ       100000000
`define DTP_TB_DIV       (`DTP_CLK_HZ / `DTP_TB_HZ)
`endif

//--- core/dtp_pkg.sv
/*
 types shared by the timer pacer files.
 assumes dtp_regs.svh is on the include path.
*/
package dtp_pkg;
    typedef struct packed {
        logic        cascade_in;
        logic        cascade_out;
        logic        input_pacer_sample_enable;
        logic        output_pacer_enable;
        logic        external_trigger_enable;
        logic        trigger_edge_select;
        logic        software_output_trigger;
    } dtp_ctrl_s;

    typedef enum logic [1:0] {
        DTP_IDLE,
        DTP_WAIT_TRIG,
        DTP_RUN
    } dtp_in_state_e;
endpackage : dtp_pkg

//--- core/dtp_down_counter.sv
/*
 16-bit reloading down-counter, one pacer pulse per period.
 assumes tick marks one time-base cycle of the source clock.
*/
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_down_counter #(
    parameter int CNT_W = `DTP_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    input  wire logic             tick,
    input  wire logic [CNT_W-1:0] divisor,
    output logic                  pulse,
    output logic                  level
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] div_eff;
    logic [CNT_W-1:0] cnt_nxt;
    localparam logic [CNT_W-1:0] MIN_DIV = CNT_W'(`DTP_MIN_DIV);
    localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

    // clamp divisor to two
    assign div_eff = (divisor < MIN_DIV) ? MIN_DIV : divisor;
    assign cnt_nxt = (cnt_r <= ONE) ? div_eff : (cnt_r - ONE);

    // reload at terminal count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= CNT_W'(`DTP_RST_DIV);
        end else if (ce && tick) begin
            if (cnt_r <= ONE) begin
                cnt_r <= div_eff;
            end else begin
                cnt_r <= cnt_r - ONE;
            end
        end
    end

    // one pulse per period, square level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pulse <= 1'b0;
            level <= 1'b1;
        end else if (ce) begin
            pulse <= tick && (cnt_r <= ONE);
            if (tick) begin
                level <= (cnt_nxt > (div_eff >> 1));
            end
        end
    end
endmodule : dtp_down_counter

//--- core/dio_timer_pacer.sv
/*
 timer pacer: time-base divider, three down-counters, cascade
 select, input sampling, output update and trigger lines.
 assumes 100 MHz clk, synchronous inputs, plain control ports.
*/
// Behaviour
// - input sampling pacer comes from timer 0.
// - output update pacer comes from timer 1.
// - timer 2 can prescale ahead of timer 0.
// - timer 2 can prescale ahead of timer 1.
// - cascaded rate is time base over timer divisor times prescale.
// - uncascaded rate is time base over timer divisor alone.
// - effective divisor is never below two.
// - each stage takes divisors up to 65535.
// - software output trigger line follows a software level.
// - inputs are latched on each falling edge of timer 0 output while input sampling is active.
// - next output word moves out when timer 1 output goes low.
// - edge select picks rising on 1 and falling on 0.
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dio_timer_pacer #(
    parameter int CNT_W  = `DTP_CNT_W,
    parameter int DATA_W = `DTP_DATA_W,
    parameter int TB_DIV = `DTP_TB_DIV
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              ce,
    input  wire dtp_pkg::dtp_ctrl_s ctrl,
    input  wire logic [CNT_W-1:0]  input_timer_divisor,
    input  wire logic [CNT_W-1:0]  output_timer_divisor,
    input  wire logic [CNT_W-1:0]  prescale_divisor,
    input  wire logic              input_start_trigger,
    input  wire logic [DATA_W-1:0] din,
    input  wire logic [DATA_W-1:0] out_word,
    input  wire logic              out_word_valid,
    output logic                   out_word_ready,
    output logic [DATA_W-1:0]      din_sample_r,
    output logic                   din_sample_valid_r,
    output logic [DATA_W-1:0]      dout_r,
    output logic                   input_pacer_out,
    output logic                   output_pacer_out,
    output logic                   software_output_trigger,
    output logic                   input_sampling_active
);
    localparam int TB_W = $clog2(TB_DIV + 1);
    logic [TB_W-1:0]    tb_cnt_r;
    logic               tb_tick;
    logic [2:0]         tick;
    logic [2:0]         pulse;
    logic [2:0]         level;
    logic [2:0]         level_d_r;
    logic [CNT_W-1:0]   div [3];
    logic               trig_d_r;
    logic               trig_hit;
    logic               in_fall;
    logic               out_fall;
    dtp_pkg::dtp_in_state_e state_r;

    // 4 MHz time base from clk
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tb_cnt_r <= '0;
        end else if (ce) begin
            if (tb_cnt_r == TB_W'(TB_DIV - 1)) begin
                tb_cnt_r <= '0;
            end else begin
                tb_cnt_r <= tb_cnt_r + TB_W'(1);
            end
        end
    end
    assign tb_tick = (tb_cnt_r == TB_W'(TB_DIV - 1));


    assign div[0] = input_timer_divisor;
    assign div[1] = output_timer_divisor;
    assign div[2] = prescale_divisor;
    // cascade select
    assign tick[2] = tb_tick;
    assign tick[0] = ctrl.cascade_in ? pulse[2] : tb_tick;
    assign tick[1] = ctrl.cascade_out ? pulse[2] : tb_tick;


    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_tmr
            dtp_down_counter #(
                .CNT_W   (CNT_W)
            ) u_cnt (
                .clk     (clk),
                .sys_rst (sys_rst),
                .ce      (ce),
                .tick    (tick[g]),
                .divisor (div[g]),
                .pulse   (pulse[g]),
                .level   (level[g])
            );
        end
    endgenerate


    assign input_pacer_out  = level[0];
    assign output_pacer_out = level[1];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_d_r <= 3'h7;
            trig_d_r  <= 1'b0;
        end else if (ce) begin
            level_d_r <= level;
            trig_d_r  <= input_start_trigger;
        end
    end

    assign in_fall  = level_d_r[0] && !level[0];
    assign out_fall = level_d_r[1] && !level[1];
    assign trig_hit = ctrl.trigger_edge_select ?
                      (input_start_trigger && !trig_d_r) :
                      (!input_start_trigger && trig_d_r);

    // start control for input sampling
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= dtp_pkg::DTP_IDLE;
        end else if (ce) begin
            case (state_r)
                dtp_pkg::DTP_IDLE: begin
                    if (ctrl.input_pacer_sample_enable) begin
                        state_r <= ctrl.external_trigger_enable ?
                                   dtp_pkg::DTP_WAIT_TRIG :
                                   dtp_pkg::DTP_RUN;
                    end
                end
                dtp_pkg::DTP_WAIT_TRIG: begin
                    if (!ctrl.input_pacer_sample_enable) begin
                        state_r <= dtp_pkg::DTP_IDLE;
                    end else if (trig_hit) begin
                        state_r <= dtp_pkg::DTP_RUN;
                    end
                end
                dtp_pkg::DTP_RUN: begin
                    if (!ctrl.input_pacer_sample_enable) begin
                        state_r <= dtp_pkg::DTP_IDLE;
                    end
                end
                default: state_r <= dtp_pkg::DTP_IDLE;
            endcase
        end
    end

    assign input_sampling_active = (state_r == dtp_pkg::DTP_RUN);

    // input latch on timer 0 falling edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            din_sample_r       <= '0;
            din_sample_valid_r <= 1'b0;
        end else if (ce) begin
            din_sample_valid_r <= 1'b0;
            if (input_sampling_active && in_fall) begin
                din_sample_r       <= din;
                din_sample_valid_r <= 1'b1;
            end
        end
    end


    // output word moves on timer 1 falling edge
    assign out_word_ready = ce && ctrl.output_pacer_enable && out_fall;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dout_r <= '0;
        end else if (out_word_ready && out_word_valid) begin
            dout_r <= out_word;
        end
    end

    // software output trigger level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            software_output_trigger <= 1'b0;
        end else if (ce) begin
            software_output_trigger <= ctrl.software_output_trigger;
        end
    end
endmodule : dio_timer_pacer

//--- dv/dtp_pacer_monitor.sv
/*
 port checks for the timer pacer.
 assumes bind onto dio_timer_pacer, one clk domain, ce held high.
*/
`timescale 1ns/1ps
module dtp_pacer_monitor #(
    parameter int DATA_W = 32
) (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire dtp_pkg::dtp_ctrl_s ctrl,
    input wire logic [DATA_W-1:0]  din,
    input wire logic [DATA_W-1:0]  out_word,
    input wire logic               out_word_valid,
    input wire logic               out_word_ready,
    input wire logic [DATA_W-1:0]  din_sample_r,
    input wire logic               din_sample_valid_r,
    input wire logic [DATA_W-1:0]  dout_r,
    input wire logic               input_pacer_out,
    input wire logic               output_pacer_out,
    input wire logic               software_output_trigger,
    input wire logic               input_sampling_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    swtrig_follow_a: assert property (
        !$past(sys_rst) |-> software_output_trigger ==
        $past(ctrl.software_output_trigger)) else $error("trigger lag");
    sample_take_a: assert property (
        $fell(input_pacer_out) && input_sampling_active |=>
        din_sample_valid_r && din_sample_r == $past(din))
        else $error("input sample missed");
    sample_cause_a: assert property (
        din_sample_valid_r |-> $past(input_pacer_out, 2) &&
        !$past(input_pacer_out) && $past(input_sampling_active))
        else $error("sample without timer fall");
    sample_pulse_a: assert property (
        din_sample_valid_r |=> !din_sample_valid_r) else $error("valid long");
    idle_refuse_a: assert property (
        !ctrl.input_pacer_sample_enable |=> !input_sampling_active)
        else $error("sampling while disabled");
    ready_cause_a: assert property (
        out_word_ready |-> ctrl.output_pacer_enable && !output_pacer_out &&
        $past(output_pacer_out)) else $error("ready without fall");
    out_move_a: assert property (
        out_word_ready && out_word_valid |=> dout_r == $past(out_word))
        else $error("output word not moved");
    dout_hold_a: assert property (
        !(out_word_ready && out_word_valid) |=> $stable(dout_r))
        else $error("output changed unasked");
endmodule : dtp_pacer_monitor

//--- dv/dtp_peripheral.sv
/*
 far-side peripheral: data lines and start trigger.
 assumes clk of the pacer; data changes every cycle.
*/
`timescale 1ns/1ps
module dtp_peripheral (
    input  wire logic        clk,
    input  wire logic        trig_level,
    output logic [31:0]      din,
    output logic             input_start_trigger
);
    initial begin
        din = 32'h0;
        input_start_trigger = 1'b0;
    end
    always @(posedge clk) begin
        din <= #1 din + 32'h01030507;
        input_start_trigger <= #1 trig_level;
    end
endmodule : dtp_peripheral

//--- dv/test_dio_timer_pacer.sv
/*
 self-checking bench for the timer pacer.
 assumes core files compiled first; short time base of one clk.
*/
`timescale 1ns/1ps
module test_dio_timer_pacer;
    localparam int TB = 1;
    logic clk = 0, sys_rst = 1, ce = 1, trig_level = 0, out_word_valid = 0;
    dtp_pkg::dtp_ctrl_s ctrl = '0;
    logic [15:0] div_in = 16'h2, div_out = 16'h2, div_pre = 16'h2;
    logic [31:0] din, out_word = 32'h0, din_sample_r, dout_r, w, exp_w;
    logic out_word_ready, din_sample_valid_r, input_pacer_out;
    logic output_pacer_out, software_output_trigger, input_sampling_active;
    logic input_start_trigger;
    int n_errors = 0, checks_done = 0, seed = 10, cyc = 0, c0;
    dio_timer_pacer #(.TB_DIV(TB)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .ce(ce), .ctrl(ctrl), .input_timer_divisor(div_in),
        .output_timer_divisor(div_out), .prescale_divisor(div_pre),
        .input_start_trigger(input_start_trigger), .din(din),
        .out_word(out_word), .out_word_valid(out_word_valid),
        .out_word_ready(out_word_ready), .din_sample_r(din_sample_r),
        .din_sample_valid_r(din_sample_valid_r), .dout_r(dout_r),
        .input_pacer_out(input_pacer_out), .output_pacer_out(output_pacer_out),
        .software_output_trigger(software_output_trigger),
        .input_sampling_active(input_sampling_active));
    dtp_peripheral i_per (.clk(clk), .trig_level(trig_level), .din(din),
        .input_start_trigger(input_start_trigger));
    initial forever #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task wait_fall(input bit sel);
        for (int k = 0; k < 4000 && (sel ? output_pacer_out
            : input_pacer_out) !== 1'b1; k++) tick(1);
        for (int k = 0; k < 4000 && (sel ? output_pacer_out
            : input_pacer_out) !== 1'b0; k++) tick(1);
    endtask : wait_fall
    function int eff(input logic [15:0] d);
        return (d < 16'h2) ? 2 : int'(d);
    endfunction : eff
    function int exp_per(input logic [15:0] d, input logic c);
        return eff(d) * (c ? eff(div_pre) : 1) * TB;
    endfunction : exp_per
    task period(input bit sel, input int e);
        wait_fall(sel);
        wait_fall(sel);
        c0 = cyc;
        wait_fall(sel);
        check(32'(cyc - c0), 32'(e));
    endtask : period
    task stop_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        stop_test();
    end
    initial begin
        tick(12);
        sys_rst = 0;
        tick(65600);
        for (int i = 0; i < 6; i++) begin
            div_in = (i == 0) ? 16'h0 : 16'(($random(seed)) & 7);
            div_out = (i == 1) ? 16'h1 : 16'(($random(seed)) & 7);
            div_pre = 16'(($random(seed)) & 7);
            ctrl.cascade_in = i[0];
            ctrl.cascade_out = i[1];
            period(0, exp_per(div_in, ctrl.cascade_in));
            period(1, exp_per(div_out, ctrl.cascade_out));
        end
        div_out = 16'h4;
        exp_w = dout_r;
        for (int j = 0; j < 3; j++) begin
            w = $random(seed);
            ctrl.output_pacer_enable = (j != 2);
            out_word = w;
            out_word_valid = (j != 1);
            if (j == 0) exp_w = w;
            wait_fall(1);
            tick(2);
            check(dout_r, exp_w);
        end
        for (int b = 0; b < 2; b++) begin
            ctrl.software_output_trigger = b[0];
            tick(2);
            check(32'(software_output_trigger), 32'(b));
        end
        ctrl.input_pacer_sample_enable = 1;
        tick(2);
        check(32'(input_sampling_active), 32'h1);
        for (int k = 0; k < 500 && din_sample_valid_r !== 1'b1; k++) tick(1);
        check(32'(din_sample_valid_r), 32'h1);
        for (int e = 0; e < 2; e++) begin
            ctrl.input_pacer_sample_enable = 0;
            ctrl.trigger_edge_select = e[0];
            ctrl.external_trigger_enable = 1;
            trig_level = ~e[0];
            tick(4);
            check(32'(input_sampling_active), 32'h0);
            ctrl.input_pacer_sample_enable = 1;
            tick(4);
            check(32'(input_sampling_active), 32'h0);
            trig_level = e[0];
            tick(5);
            check(32'(input_sampling_active), 32'h1);
        end
        stop_test();
    end
endmodule : test_dio_timer_pacer
bind dio_timer_pacer dtp_pacer_monitor #(.DATA_W(DATA_W)) i_mon (
    .clk(clk), .sys_rst(sys_rst), .ctrl(ctrl), .din(din),
    .out_word(out_word), .out_word_valid(out_word_valid),
    .out_word_ready(out_word_ready), .din_sample_r(din_sample_r),
    .din_sample_valid_r(din_sample_valid_r), .dout_r(dout_r),
    .input_pacer_out(input_pacer_out), .output_pacer_out(output_pacer_out),
    .software_output_trigger(software_output_trigger),
    .input_sampling_active(input_sampling_active));
